// ### inc/bsfl_pkg.sv
package bsfl_pkg;
    localparam int CLK_HZ          = 200_000_000;
    localparam int SPI_HZ          = 12_000_000;
    // Half period rounds up so the serial clock never exceeds its limit.
    localparam int SPI_HALF_CYC    = (CLK_HZ + 2 * SPI_HZ - 1) / (2 * SPI_HZ);
    localparam int STRAP_SETTLE_NS = 100;
    localparam int STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RETRY_GAP_NS    = 1000;
    localparam int RETRY_GAP_CYC   = (RETRY_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    localparam logic [3:0]  IF1_ADDR_HI     = 4'h2;
    localparam logic [6:0]  IF2_P1_ADDR     = 7'h38;
    localparam logic [6:0]  IF2_P2_ADDR     = 7'h3f;
    localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
    localparam logic [7:0]  BLANK_BYTE      = 8'hff;
    localparam logic [5:0]  CMD_BITS        = 6'h20;
    localparam logic [5:0]  BYTE_BITS       = 6'h08;

    // Divider ratio thresholds, ratio scaled to full scale of 256.
    localparam logic [7:0]  DIV_TH_019      = 8'h30;
    localparam logic [7:0]  DIV_TH_029      = 8'h4a;
    localparam logic [7:0]  DIV_TH_039      = 8'h63;
    localparam logic [7:0]  DIV_TH_049      = 8'h7d;
    localparam logic [7:0]  DIV_TH_059      = 8'h97;

    typedef enum logic [2:0] {
        no_response_boot,
        hold_for_supply_internal_path,
        retry_load_internal_path,
        hold_for_supply_external_path,
        load_once_boot
    } bsfl_boot_mode_t;

    typedef enum logic [3:0] {
        ST_INIT, ST_STRAP, ST_SUPPLY, ST_CMD, ST_DATA, ST_PUSH, ST_GAP, ST_DONE, ST_SAFE
    } bsfl_state_t;

    // Address strap band: ground gives band 0, regulator output band 3.
    function automatic logic [1:0] addr_band(input logic [7:0] ratio);
        if (ratio < DIV_TH_019)
            return 2'h0;
        else if (ratio < DIV_TH_039)
            return 2'h1;
        else if (ratio < DIV_TH_059)
            return 2'h2;
        else
            return 2'h3;
    endfunction

    function automatic bsfl_boot_mode_t boot_mode(input logic [7:0] ratio,
                                                  input logic       strap_hi);
        if (!strap_hi || ratio >= DIV_TH_049)
            return load_once_boot;
        else if (ratio < DIV_TH_019)
            return no_response_boot;
        else if (ratio < DIV_TH_029)
            return hold_for_supply_internal_path;
        else if (ratio < DIV_TH_039)
            return retry_load_internal_path;
        else
            return hold_for_supply_external_path;
    endfunction

    function automatic logic [6:0] apply_mask(input logic [6:0] dflt,
                                              input logic [6:0] mask,
                                              input logic [6:0] fw);
        return (dflt & ~mask) | (fw & mask);
    endfunction
endpackage

// ### inc/bsfl_stream_if.sv
`timescale 1ns/10ps
interface bsfl_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### verilog/bsfl_fifo.sv
`timescale 1ns/10ps
module bsfl_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    bsfl_stream_if.snk    wr,
    bsfl_stream_if.src    rd
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } bsfl_fifo_reg_t;

    generate
        if (D < 2 || (D & (D - 1)) != 0)
        begin : g_bad_depth
            $error("bsfl_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0]   mem [D];
    bsfl_fifo_reg_t r_q;
    bsfl_fifo_reg_t r_d;
    logic           full;
    logic           empty;

    // Extra pointer bit tells a full buffer from an empty one.
    assign full     = (r_q.wp[AW] != r_q.rp[AW]) && (r_q.wp[AW-1:0] == r_q.rp[AW-1:0]);
    assign empty    = (r_q.wp == r_q.rp);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[r_q.rp[AW-1:0]];

    // Pointer update.
    always_comb
    begin
        r_d = r_q;
        if (wr.valid && !full)
            r_d.wp = r_q.wp + 1'b1;
        if (rd.ready && !empty)
            r_d.rp = r_q.rp + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    // Storage has no reset; stale words show on rd.data while empty, but rd.valid stays low.
    always_ff @(posedge clk)
    begin
        if (wr.valid && !full)
            mem[r_q.wp[AW-1:0]] <= wr.data;
    end
endmodule

// ### verilog/bsfl_top.sv
`timescale 1ns/10ps
module bsfl_top
    import bsfl_pkg::*;
#(
    parameter int          LOAD_BYTES = 256,
    parameter logic [23:0] FLASH_BASE = 24'h000000,
    parameter int          FIFO_DEPTH = 16
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic [7:0]      boot_strap_divider_pin,
    input  wire logic [7:0]      address_strap_divider_pin,
    input  wire logic            supply_3v3_present,
    input  wire logic            low_power_req,
    output logic                 flash_sclk,
    output logic                 flash_cs_n,
    output logic                 flash_mosi,
    input  wire logic            flash_miso,
    output logic [7:0]           cfg_data,
    output logic                 cfg_valid,
    input  wire logic            cfg_ready,
    input  wire logic [3:0][6:0] fw_addr_mask,
    input  wire logic [3:0][6:0] fw_addr_value,
    input  wire logic            host_frame_start,
    input  wire logic            host_byte_valid,
    input  wire logic [7:0]      host_byte,
    input  wire logic            host_iface,
    output logic                 host_addr_ack,
    output logic                 host_sub_valid,
    output logic [1:0]           host_sub_index,
    output logic [7:0]           host_sub_code,
    output logic [3:0][6:0]      slave_addr,
    output logic                 addr_ready,
    output logic [1:0]           port_one_address_code,
    output logic [2:0]           port_two_address_code,
    output logic [2:0]           dead_battery_mode,
    output logic                 boot_done,
    output logic                 ports_disabled,
    output logic                 legacy_sink,
    output logic                 core_clk_slow_sel
);
    typedef struct packed {
        bsfl_state_t     st;
        logic [15:0]     cnt;
        logic [3:0]      div;
        logic            sclk;
        logic            cs_n;
        logic            mosi;
        logic [5:0]      bitn;
        logic [31:0]     sh;
        logic [7:0]      rx;
        logic [15:0]     left;
        logic            first;
        logic            push_v;
        logic [18:0]     s1;
        logic [18:0]     s2;
        logic [1:0]      acode;
        bsfl_boot_mode_t mode;
        logic            addr_ok;
        logic            safe;
        logic            loaded;
        logic            slow;
        logic [3:0][6:0] eff;
        logic            exp_addr;
        logic            exp_sub;
        logic [1:0]      hidx;
        logic            sub_v;
        logic [1:0]      sub_idx;
        logic [7:0]      sub_code;
    } bsfl_reg_t;

    localparam bsfl_reg_t RST_VAL = '{st: ST_INIT, mode: load_once_boot, cs_n: 1'b1,
                                      cnt: '0, div: '0, sclk: 1'b0, mosi: 1'b0,
                                      bitn: '0, sh: '0, rx: '0, left: '0, first: 1'b0,
                                      push_v: 1'b0, s1: '0, s2: '0, acode: '0,
                                      addr_ok: 1'b0, safe: 1'b0, loaded: 1'b0,
                                      slow: 1'b0, eff: '0, exp_addr: 1'b0,
                                      exp_sub: 1'b0, hidx: '0, sub_v: 1'b0,
                                      sub_idx: '0, sub_code: '0};
    localparam logic [3:0]  DIV_LAST    = 4'(SPI_HALF_CYC - 1);
    localparam logic [15:0] SETTLE_LAST = 16'(STRAP_SETTLE_CYC - 1);
    localparam logic [15:0] RETRY_LAST  = 16'(RETRY_GAP_CYC - 1);
    localparam logic [15:0] LOAD_CNT    = 16'(LOAD_BYTES);

    if (LOAD_BYTES < 1 || LOAD_BYTES > 65535 || SPI_HALF_CYC > 16)
    begin : g_bad_param
        $error("bsfl_top load length or serial clock divider out of range");
    end

    logic      [1:0] rst_sync;
    logic            rst_n;
    bsfl_reg_t       r_q;
    bsfl_reg_t       r_d;
    logic            miso_s;
    logic            supply_s;
    logic            lowpwr_s;
    logic            rise;
    logic            fall;
    logic      [2:0] hit;
    logic            retry_mode;
    logic            hold_mode;

    bsfl_stream_if #(.W(8)) push_if ();
    bsfl_stream_if #(.W(8)) pop_if ();

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Address byte decode against the two effective slave addresses of the selected interface.
    function automatic logic [2:0] match(input logic [7:0]      b,
                                         input logic            iface,
                                         input logic [3:0][6:0] eff);
        if (b[7:1] == eff[{iface, 1'b0}])
            return {1'b1, iface, 1'b0};
        else if (b[7:1] == eff[{iface, 1'b1}])
            return {1'b1, iface, 1'b1};
        else
            return 3'h0;
    endfunction

    assign miso_s     = r_q.s2[2];
    assign supply_s   = r_q.s2[1];
    assign lowpwr_s   = r_q.s2[0];
    assign rise       = (r_q.div == DIV_LAST) && !r_q.sclk;
    assign fall       = (r_q.div == DIV_LAST) && r_q.sclk;
    assign hit        = match(host_byte, host_iface, r_q.eff);
    assign retry_mode = (r_q.mode == retry_load_internal_path);
    assign hold_mode  = (r_q.mode == no_response_boot) ||
                        (r_q.mode == hold_for_supply_internal_path) ||
                        (r_q.mode == hold_for_supply_external_path);

    // Boot sequencer, serial flash master and host address decoder.
    always_comb
    begin
        r_d        = r_q;
        r_d.s1     = {boot_strap_divider_pin, address_strap_divider_pin,
                      flash_miso, supply_3v3_present, low_power_req};
        r_d.s2     = r_q.s1;
        r_d.sub_v  = 1'b0;
        r_d.slow   = lowpwr_s;
        // Overrides stay live; addr_ok lags the strap code a cycle, so no stale address shows.
        r_d.eff[0] = apply_mask({IF1_ADDR_HI, 1'b0, r_q.acode},
                                fw_addr_mask[0], fw_addr_value[0]);
        r_d.eff[1] = apply_mask({IF1_ADDR_HI, 1'b1, r_q.acode},
                                fw_addr_mask[1], fw_addr_value[1]);
        r_d.eff[2] = apply_mask(IF2_P1_ADDR, fw_addr_mask[2], fw_addr_value[2]);
        r_d.eff[3] = apply_mask(IF2_P2_ADDR, fw_addr_mask[3], fw_addr_value[3]);
        // The divider runs only while a transfer is live, so the clock idles low.
        if ((r_q.st == ST_CMD) || (r_q.st == ST_DATA))
        begin
            r_d.div = (r_q.div == DIV_LAST) ? 4'h0 : r_q.div + 4'h1;
            if (r_q.div == DIV_LAST)
                r_d.sclk = !r_q.sclk;
        end
        case (r_q.st)
            ST_INIT:
            begin
                // Registers come up at their reset values, then straps settle.
                r_d.cnt = r_q.cnt + 16'h1;
                if (r_q.cnt == SETTLE_LAST)
                    r_d.st = ST_STRAP;
            end
            ST_STRAP:
            begin
                r_d.acode   = addr_band(r_q.s2[10:3]);
                r_d.mode    = boot_mode(r_q.s2[18:11], miso_s);
                r_d.st      = ST_SUPPLY;
            end
            ST_SUPPLY:
            begin
                r_d.addr_ok = 1'b1;
                if (!hold_mode || supply_s)
                    r_d.st = ST_GAP;
                r_d.cnt = RETRY_LAST;
            end
            ST_GAP:
            begin
                // Count down, then open a read with the first bit already out.
                r_d.cnt = r_q.cnt - 16'h1;
                if (r_q.cnt == 16'h0)
                begin
                    r_d.st    = ST_CMD;
                    r_d.cs_n  = 1'b0;
                    r_d.sh    = {FLASH_READ_CMD, FLASH_BASE};
                    r_d.mosi  = FLASH_READ_CMD[7];
                    r_d.bitn  = CMD_BITS;
                    r_d.div   = 4'h0;
                    r_d.sclk  = 1'b0;
                    r_d.left  = LOAD_CNT;
                    r_d.first = 1'b1;
                end
            end
            ST_CMD:
            begin
                if (fall)
                begin
                    r_d.sh   = {r_q.sh[30:0], 1'b0};
                    r_d.mosi = r_q.sh[30];
                    r_d.bitn = r_q.bitn - 6'h1;
                    if (r_q.bitn == 6'h1)
                    begin
                        r_d.st   = ST_DATA;
                        r_d.bitn = BYTE_BITS;
                        r_d.mosi = 1'b0;
                    end
                end
            end
            ST_DATA:
            begin
                if (rise)
                    r_d.rx = {r_q.rx[6:0], miso_s};
                if (fall)
                begin
                    r_d.bitn = r_q.bitn - 6'h1;
                    if (r_q.bitn == 6'h1)
                    begin
                        r_d.st     = ST_PUSH;
                        r_d.push_v = 1'b1;
                        r_d.div    = 4'h0;
                    end
                end
            end
            ST_PUSH:
            begin
                // Clock is parked low here while the buffer is full.
                if (push_if.ready)
                begin
                    r_d.push_v = 1'b0;
                    r_d.first  = 1'b0;
                    r_d.left   = r_q.left - 16'h1;
                    r_d.bitn   = BYTE_BITS;
                    if (r_q.first && (r_q.rx == BLANK_BYTE))
                    begin
                        // Blank flash: end the frame, then retry or fall back.
                        r_d.cs_n = 1'b1;
                        r_d.cnt  = RETRY_LAST;
                        r_d.st   = retry_mode ? ST_GAP : ST_SAFE;
                    end
                    else if (r_q.left == 16'h1)
                    begin
                        r_d.cs_n   = 1'b1;
                        r_d.loaded = 1'b1;
                        r_d.st     = ST_DONE;
                    end
                    else
                        r_d.st = ST_DATA;
                end
            end
            ST_SAFE:
            begin
                r_d.safe = 1'b1;
                r_d.st   = ST_DONE;
            end
            ST_DONE:
                r_d.st = ST_DONE;
            default:
                r_d.st = ST_INIT;
        endcase
        // Host side: address byte first, then the sub-address byte of a write.
        if (host_frame_start)
        begin
            r_d.exp_addr = 1'b1;
            r_d.exp_sub  = 1'b0;
        end
        else if (host_byte_valid && r_q.exp_addr)
        begin
            r_d.exp_addr = 1'b0;
            r_d.exp_sub  = r_q.addr_ok && hit[2] && !host_byte[0];
            r_d.hidx     = hit[1:0];
        end
        else if (host_byte_valid && r_q.exp_sub)
        begin
            r_d.exp_sub  = 1'b0;
            r_d.sub_v    = 1'b1;
            r_d.sub_idx  = r_q.hidx;
            r_d.sub_code = host_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_q <= RST_VAL;
        else
            r_q <= r_d;
    end

    assign push_if.valid = r_q.push_v;
    assign push_if.data  = r_q.rx;

    // Bundle bytes queue here so a slow consumer stalls the flash read.
    bsfl_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (push_if),
        .rd    (pop_if)
    );

    assign cfg_data              = pop_if.data;
    assign cfg_valid             = pop_if.valid;
    assign pop_if.ready          = cfg_ready;
    assign flash_sclk            = r_q.sclk;
    assign flash_cs_n            = r_q.cs_n;
    assign flash_mosi            = r_q.mosi;
    assign host_addr_ack         = r_q.exp_addr && host_byte_valid && hit[2] && r_q.addr_ok;
    assign host_sub_valid        = r_q.sub_v;
    assign host_sub_index        = r_q.sub_idx;
    assign host_sub_code         = r_q.sub_code;
    assign slave_addr            = r_q.eff;
    assign addr_ready            = r_q.addr_ok;
    assign port_one_address_code = r_q.acode;
    assign port_two_address_code = {1'b1, r_q.acode};
    assign dead_battery_mode     = r_q.mode;
    assign boot_done             = (r_q.st == ST_DONE);
    assign ports_disabled        = r_q.safe;
    assign legacy_sink           = r_q.safe && !supply_s;
    assign core_clk_slow_sel     = r_q.slow;
endmodule

// ### test/bsfl_monitor.sv
`timescale 1ns/10ps
module bsfl_monitor
    import bsfl_pkg::*;
(
    input wire logic            clk,
    input wire logic            rstn,
    input wire logic            flash_sclk,
    input wire logic            flash_cs_n,
    input wire logic            flash_mosi,
    input wire logic            low_power_req,
    input wire logic            core_clk_slow_sel,
    input wire logic            supply_3v3_present,
    input wire logic            addr_ready,
    input wire logic            host_byte_valid,
    input wire logic            host_addr_ack,
    input wire logic            host_sub_valid,
    input wire logic [3:0][6:0] fw_addr_mask,
    input wire logic [3:0][6:0] fw_addr_value,
    input wire logic [3:0][6:0] slave_addr,
    input wire logic [1:0]      port_one_address_code,
    input wire logic [2:0]      port_two_address_code,
    input wire logic [2:0]      dead_battery_mode,
    input wire logic            ports_disabled,
    input wire logic            legacy_sink
);
    logic [3:0][6:0] dflt, eff;
    logic            last_q;
    logic [15:0]     run_q;

    // Default addresses, interface 1 built from the strap codes and interface 2 fixed, then the firmware override.
    assign dflt = {7'h3f, 7'h38, {IF1_ADDR_HI, port_two_address_code},
                   {IF1_ADDR_HI, 1'b0, port_one_address_code}};
    assign eff  = (dflt & ~fw_addr_mask) | (fw_addr_value & fw_addr_mask);

    // Counts in-frame samples at the present clock level; cleared between frames.
    always_ff @(posedge clk)
    begin
        last_q <= flash_sclk;
        run_q  <= flash_cs_n ? 16'h0 : (flash_sclk != last_q) ? 16'h1 : run_q + 16'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // A frame opens low with the first bit out, then rises after one half period.
    sequence s_open;
        $fell(flash_cs_n) && !flash_mosi && !flash_sclk;
    endsequence
    sequence s_first_rise;
        $rose(flash_sclk) && run_q == 16'(SPI_HALF_CYC);
    endsequence

    a_select_first_bit: assert property (s_open |-> ##9 s_first_rise)
        else $error("first bit or select timing wrong");
    a_sclk_half_period: assert property ($fell(flash_sclk) |-> run_q == 16'(SPI_HALF_CYC))
        else $error("serial clock high time wrong");
    a_sclk_idle_low: assert property (flash_cs_n |-> !flash_sclk)
        else $error("serial clock not low while idle");
    a_mosi_on_fall: assert property (!flash_cs_n && $past(!flash_cs_n) && $changed(flash_mosi)
        |-> $fell(flash_sclk)) else $error("data changed off the falling edge");
    a_code_pair: assert property (addr_ready |-> port_two_address_code == {1'b1, port_one_address_code})
        else $error("second port code mismatch");
    a_addr_effective: assert property (addr_ready && $stable(fw_addr_mask) && $stable(fw_addr_value)
        |-> slave_addr == eff) else $error("effective address wrong");
    a_ack_gated: assert property (host_addr_ack |-> addr_ready && host_byte_valid)
        else $error("acknowledge without ready address");
    a_sub_pulse: assert property (host_sub_valid |=> !host_sub_valid)
        else $error("sub address strobe longer than a cycle");
    a_clock_select: assert property ($stable(low_power_req) [*8] |-> core_clk_slow_sel == low_power_req)
        else $error("clock select does not follow request");
    a_safe_sink: assert property (legacy_sink |-> ports_disabled)
        else $error("legacy sink without disabled ports");
    a_hold_supply: assert property (addr_ready && dead_battery_mode inside {3'h0, 3'h1, 3'h3}
        && !supply_3v3_present |-> flash_cs_n) else $error("flash read before supply");
endmodule

bind bsfl_top bsfl_monitor i_bsfl_monitor (.clk(clk), .rstn(rstn), .flash_sclk(flash_sclk),
    .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi), .low_power_req(low_power_req),
    .core_clk_slow_sel(core_clk_slow_sel), .supply_3v3_present(supply_3v3_present),
    .addr_ready(addr_ready), .host_byte_valid(host_byte_valid), .host_addr_ack(host_addr_ack),
    .host_sub_valid(host_sub_valid), .fw_addr_mask(fw_addr_mask), .fw_addr_value(fw_addr_value),
    .slave_addr(slave_addr), .port_one_address_code(port_one_address_code),
    .port_two_address_code(port_two_address_code), .dead_battery_mode(dead_battery_mode),
    .ports_disabled(ports_disabled), .legacy_sink(legacy_sink));

// ### test/bsfl_flash_model.sv
`timescale 1ns/10ps
module bsfl_flash_model #(
    parameter int N = 20
) (
    input  wire logic           sclk,
    input  wire logic           cs_n,
    input  wire logic           mosi,
    input  wire logic           strap,
    input  wire logic [8*N-1:0] image,
    output logic                miso,
    output logic [31:0]         header
);
    int   cnt = 0;
    logic bit_q = 1'b0;

    // Deselected or still in the header, the line rests at the strap pull level.
    assign miso = (cs_n || cnt < 32) ? strap : (cnt < 32 + 8 * N) ? bit_q : ~bit_q;

    // Each new frame starts counting from the command again.
    always @(negedge cs_n) cnt = 0;

    // Command and address bits are taken on the rising edge.
    always @(posedge sclk)
    begin
        if (!cs_n && cnt < 32)
            header <= {header[30:0], mosi};
        if (!cs_n)
            cnt = cnt + 1;
    end

    // Stored bits leave on the falling edge, most significant first.
    always @(negedge sclk)
        if (!cs_n && cnt >= 32 && cnt < 32 + 8 * N)
            bit_q <= image[8*N-1-(cnt-32)];
endmodule

// ### test/bsfl_top_bench.sv
`timescale 1ns/10ps
module bsfl_top_bench
    import bsfl_pkg::*;
;
    localparam int          N    = 20;
    localparam logic [23:0] BASE = 24'h00a5c3;
    logic            clk = 0, rstn, sup, lp, miso, sclk, cs_n, mosi, cv, crdy, frm, bv, ifc;
    logic            ack, subv, ardy, done, pdis, lsink, slow, strap;
    logic [7:0]      br, ar, cdat, hb, scode;
    logic [1:0]      sidx, c1;
    logic [2:0]      c2, mode;
    logic [3:0][6:0] fm, fv, sa;
    logic [8*N-1:0]  image;
    logic [31:0]     header;
    int              mismatches = 0, n_checks = 0, cyc = 0;

    bsfl_top #(.LOAD_BYTES(N), .FLASH_BASE(BASE)) i_bsfl_top (.clk(clk), .rstn(rstn),
        .boot_strap_divider_pin(br), .address_strap_divider_pin(ar), .supply_3v3_present(sup),
        .low_power_req(lp), .flash_sclk(sclk), .flash_cs_n(cs_n), .flash_mosi(mosi),
        .flash_miso(miso), .cfg_data(cdat), .cfg_valid(cv), .cfg_ready(crdy),
        .fw_addr_mask(fm), .fw_addr_value(fv), .host_frame_start(frm), .host_byte_valid(bv),
        .host_byte(hb), .host_iface(ifc), .host_addr_ack(ack), .host_sub_valid(subv),
        .host_sub_index(sidx), .host_sub_code(scode), .slave_addr(sa), .addr_ready(ardy),
        .port_one_address_code(c1), .port_two_address_code(c2), .dead_battery_mode(mode),
        .boot_done(done), .ports_disabled(pdis), .legacy_sink(lsink), .core_clk_slow_sel(slow));
    bsfl_flash_model #(.N(N)) i_bsfl_flash_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .strap(strap), .image(image), .miso(miso), .header(header));

    // The clock and a ceiling that stops a hung run.
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // A bounded wait; running out counts as a mismatch.
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        while (s !== v && lim > 0)
        begin
            tick(1);
            lim--;
        end
        chk("wait", s, v);
    endtask

    function automatic logic [2:0] f_mode(input logic st, input logic [7:0] r);
        return (!st || r >= DIV_TH_049) ? 3'h4 : (r < DIV_TH_019) ? 3'h0 :
               (r < DIV_TH_029) ? 3'h1 : (r < DIV_TH_039) ? 3'h2 : 3'h3;
    endfunction

    function automatic logic [1:0] f_band(input logic [7:0] r);
        return (r < DIV_TH_019) ? 2'h0 : (r < DIV_TH_039) ? 2'h1 : (r < DIV_TH_059) ? 2'h2 : 2'h3;
    endfunction

    // A wrong address first, then the right one followed by a sub-address byte.
    task automatic host(input logic [3:0][6:0] ex);
        logic [1:0] j;
        logic [7:0] s;
        j = 2'($urandom);
        s = 8'($urandom);
        ifc = j[1];
        for (int p = 0; p < 2; p++)
        begin
            frm = 1;
            tick(1);
            frm = 0;
            bv = 1;
            hb = {ex[j] ^ {6'h00, p == 0}, 1'b0};
            @(negedge clk) chk("ack", ack, p);
            tick(1);
            bv = (p == 1);
            hb = s;
        end
        tick(1);
        bv = 0;
        @(negedge clk) chk("sub", {subv, sidx, scode}, {1'b1, j, s});
    endtask

    task automatic run(input int r, input logic st, input logic [7:0] b_r, input logic [7:0] a_r,
                       input logic blank, input logic s);
        logic [2:0]      m;
        logic [3:0][6:0] ex;
        int              k;
        m = f_mode(st, b_r);
        rstn = 0;
        strap = st;
        br = b_r;
        ar = a_r;
        sup = s;
        lp = 1'($urandom);
        crdy = (r != 0);
        fm = (r == 0) ? '0 : 28'({$urandom, $urandom});
        fv = 28'({$urandom, $urandom});
        for (k = 0; k < N; k++)
            image[8*N-1-8*k -: 8] = (k > 0) ? 8'($urandom) : blank ? BLANK_BYTE : 8'h5a;
        tick(3);
        chk("reset", {cs_n, sclk, cv}, 3'b100);
        rstn = 1;
        wait_sig(ardy, 1, 100);
        ex = {7'h38 ^ 7'h07, 7'h38, {IF1_ADDR_HI, 1'b1, f_band(a_r)}, {IF1_ADDR_HI, 1'b0, f_band(a_r)}};
        ex = (ex & ~fm) | (fv & fm);
        chk("codes", {c2, c1}, {1'b1, f_band(a_r), f_band(a_r)});
        chk("mode", mode, m);
        chk("addr", sa, ex);
        chk("slow", slow, lp);
        if (r == 0)
            host(ex);
        if (m != 3'h2 && m != 3'h4 && !s)
        begin
            tick(300);
            chk("hold", cs_n, 1);
            sup = 1;
        end
        wait_sig(cs_n, 0, 600);
        if (r == 0)
        begin
            tick(3500);
            chk("stall", {cs_n, sclk, cv}, 3'b001);
            for (k = 0; k < N && cyc < 30000; tick(1))
            begin
                crdy = 1'($urandom);
                @(negedge clk)
                if (cv && crdy)
                begin
                    chk("cfg", cdat, image[8*N-1-8*k -: 8]);
                    k++;
                end
            end
            crdy = 1;
        end
        wait_sig(cs_n, 1, 6000);
        tick(2);
        chk("header", header, {FLASH_READ_CMD, BASE});
        if (blank && m == 3'h2)
        begin
            wait_sig(cs_n, 0, 400);
            chk("retry", pdis, 0);
        end
        else if (blank)
            chk("safe", {pdis, lsink}, {1'b1, !sup});
        else
            chk("done", {done, cv}, 2'b10);
    endtask

    // Load-once good image, then the four strapped bands at an edge value and load-once by strap, each with a blank flash.
    initial
    begin
        {rstn, sup, lp, crdy, frm, bv, ifc, strap, br, ar, hb, fm, fv, image} = '0;
        void'($urandom(32'h233b));
        run(0, 0, 8'($urandom), 8'h00, 0, 1);
        run(1, 1, 8'h2f, 8'hff, 1, 0);
        run(2, 1, DIV_TH_019, 8'($urandom), 1, 0);
        run(3, 1, 8'h62, 8'($urandom), 1, 1);
        run(4, 1, 8'h7c, 8'($urandom), 1, 0);
        run(5, 0, 8'($urandom), 8'($urandom), 1, 0);
        stop_test();
    end
endmodule
